/* sfp_pkg.sv */
package sfp_pkg;

  // Command bytes.
  localparam logic [7:0] OP_PROT_PROG = 8'h3D;
  localparam logic [7:0] PROT_SEQ_1 = 8'h2A;
  localparam logic [7:0] PROT_SEQ_2 = 8'h7F;
  localparam logic [7:0] PROT_SEQ_3 = 8'hFC;
  localparam logic [7:0] OP_PROT_READ = 8'h32;
  localparam logic [7:0] OP_ID_READ = 8'h77;
  localparam logic [7:0] OP_PAGE_COPY = 8'h53;
  localparam logic [7:0] OP_PAGE_CMP = 8'h60;

  // Sizes and field positions.
  localparam int MAP_BYTES = 8;
  localparam int ID_BYTES = 128;
  localparam int ID_IDX_W = 7;
  localparam logic [1:0] LAST_ARG = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int PAGE_BITS = 10;
  localparam int PAGE_LSB_264 = 9;
  localparam int PAGE_LSB_256 = 8;
  localparam logic [8:0] PAGE_SIZE_264 = 9'h108;
  localparam logic [8:0] PAGE_SIZE_256 = 9'h100;
  localparam int BUF_BYTES = 264;
  localparam logic [7:0] PROT_DEFAULT = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam int FIFO_DEPTH = 4;

  // Timing, 10 MHz reference clock; longest times round down.
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROTECT_PROGRAM_TIME_NS = 200000;
  localparam int PAGE_COPY_TIME_NS = 200000;
  localparam int PAGE_COMPARE_TIME_NS = 200000;
  localparam int PROT_PROG_CYCLES = PROTECT_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int PAGE_COPY_CYCLES = PAGE_COPY_TIME_NS / CLK_PERIOD_NS;
  localparam int PAGE_CMP_CYCLES = PAGE_COMPARE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  typedef enum {
    PH_OPCODE, PH_PROT_HDR, PH_PROT_DATA, PH_DUMMY, PH_MAP_OUT, PH_ID_OUT,
    PH_ADDR, PH_ADDR_DONE, PH_IGNORE
  } sfp_phase_t;

  typedef enum {OP_IDLE, OP_PROT, OP_COPY, OP_CMP} sfp_op_t;

  typedef struct packed {
    logic ready;
    logic cmp_diff;
  } sfp_status_t;

  typedef struct packed {
    logic [PAGE_BITS-1:0] page;
    logic start;
  } sfp_mem_req_t;

endpackage : sfp_pkg

/* sfp_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("sfp_fifo needs DEPTH of at least 2 and WIDTH of at least 1.");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (ce && flush)) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sfp_fifo

`default_nettype wire

/* sfp_cmd.sv */
// Contract
// - Opcode 3Dh,2Ah,7Fh,FCh then eight map bytes rewrites the protection map.
// - Map program starts on chip-select rise; busy for at most program time.
// - Map data beyond eight bytes wraps to byte location zero.
// - Map program is accepted whether global protection is on or off.
// - Map program uses the page buffer, overwriting its contents.
// - Opcode 32h plus three dummy bytes shifts the map out.
// - Map bytes go out in ascending order, location zero first.
// - Clocks past the eighth map byte give undefined output.
// - Chip-select rise ends the map read and releases the output.
// - A fixed 128-byte identifier area exists that no command alters.
// - Opcode 77h plus three dummy bytes shifts identifier bytes out.
// - Past the last identifier byte output is undefined; chip-select rise releases it.
// - Opcode 53h plus three address bytes; page field placed by page-size mode.
// - Page copy into buffer starts on chip-select rise; busy until done.
// - Opcode 60h plus three address bytes with the same layout compares.
// - Compare starts on chip-select rise, busy meanwhile, then updates status bit 6.
// - Compare flag is 0 on equal page and 1 on any difference.
// - Ready flag in bit 7 is 0 while busy and 1 when idle.
`timescale 1ns/100ps
`default_nettype none

module sfp_cmd #(
  parameter int PROT_CYCLES = sfp_pkg::PROT_PROG_CYCLES,
  parameter int COPY_CYCLES = sfp_pkg::PAGE_COPY_CYCLES,
  parameter int CMP_CYCLES = sfp_pkg::PAGE_CMP_CYCLES,
  parameter int FIFO_DEPTH = sfp_pkg::FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  input wire logic PAGE_264,
  output sfp_pkg::sfp_status_t STATUS,
  output logic [8*sfp_pkg::MAP_BYTES-1:0] PROT_MAP,
  output logic [sfp_pkg::ID_IDX_W-1:0] ID_INDEX,
  input wire logic [7:0] ID_BYTE,
  output sfp_pkg::sfp_mem_req_t MEM_REQ,
  input wire logic [7:0] MEM_DATA,
  input wire logic MEM_VALID,
  output logic MEM_READY
);

  if (PROT_CYCLES < 1 || COPY_CYCLES < 1 || CMP_CYCLES < 1 ||
      PROT_CYCLES >= 2**sfp_pkg::TIMER_W || COPY_CYCLES >= 2**sfp_pkg::TIMER_W ||
      CMP_CYCLES >= 2**sfp_pkg::TIMER_W || FIFO_DEPTH < 2) begin : g_check
    $error("sfp_cmd timing or FIFO parameters out of range.");
  end

  localparam logic [sfp_pkg::TIMER_W-1:0] PROT_LAST = sfp_pkg::TIMER_W'(PROT_CYCLES - 1);
  localparam logic [sfp_pkg::TIMER_W-1:0] COPY_LAST = sfp_pkg::TIMER_W'(COPY_CYCLES - 1);
  localparam logic [sfp_pkg::TIMER_W-1:0] CMP_LAST = sfp_pkg::TIMER_W'(CMP_CYCLES - 1);

  // Returns the expected byte of the map-program header after the opcode.
  function automatic logic [7:0] hdr_byte(input logic [1:0] idx);
    case (idx)
      2'h0: hdr_byte = sfp_pkg::PROT_SEQ_1;
      2'h1: hdr_byte = sfp_pkg::PROT_SEQ_2;
      default: hdr_byte = sfp_pkg::PROT_SEQ_3;
    endcase
  endfunction : hdr_byte

  // Extracts the page index from the three address bytes.
  function automatic logic [sfp_pkg::PAGE_BITS-1:0] page_of(input logic [23:0] addr, input logic p264);
    logic [23:0] sh;
    sh = addr >> (p264 ? sfp_pkg::PAGE_LSB_264 : sfp_pkg::PAGE_LSB_256);
    return sh[sfp_pkg::PAGE_BITS-1:0];
  endfunction : page_of

  // Pin synchronisers; bit 0 feeds only bit 1, bit 2 is the edge history.
  logic [2:0] sck_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] si_sync_reg;
  logic cs_active;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si_bit;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sck_sync_reg <= '0;
      cs_sync_reg <= 3'h7;
      si_sync_reg <= '0;
    end else if (CE) begin
      sck_sync_reg <= {sck_sync_reg[1:0], SCK};
      cs_sync_reg <= {cs_sync_reg[1:0], CS_N};
      si_sync_reg <= {si_sync_reg[0], SI};
    end
  end

  assign cs_active = !cs_sync_reg[1];
  assign cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];
  assign sck_rise = cs_active && sck_sync_reg[1] && !sck_sync_reg[2];
  assign sck_fall = cs_active && !sck_sync_reg[1] && sck_sync_reg[2];
  assign si_bit = si_sync_reg[1];

  // Byte assembly on serial clock rising edges.
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_in_reg;
  logic byte_done;
  logic [7:0] rx_byte;

  assign byte_done = sck_rise && (bit_cnt_reg == sfp_pkg::LAST_BIT);
  assign rx_byte = {shift_in_reg, si_bit};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bit_cnt_reg <= '0;
      shift_in_reg <= '0;
    end else if (CE) begin
      if (!cs_active) begin
        bit_cnt_reg <= '0;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_in_reg <= {shift_in_reg[5:0], si_bit};
      end
    end
  end

  // Command decode.
  sfp_pkg::sfp_phase_t phase_reg;
  sfp_pkg::sfp_op_t op_reg;
  logic [1:0] arg_cnt_reg;
  logic rd_id_reg;
  logic cmp_sel_reg;
  logic [23:0] addr_reg;
  logic [2:0] data_ptr_reg;
  logic data_seen_reg;
  logic prot_wr;
  logic start_prot;
  logic start_xfer;
  logic first_out;

  assign prot_wr = byte_done && (phase_reg == sfp_pkg::PH_PROT_DATA);
  assign first_out = byte_done && (phase_reg == sfp_pkg::PH_DUMMY) && (arg_cnt_reg == sfp_pkg::LAST_ARG);
  assign start_prot = cs_rise && (phase_reg == sfp_pkg::PH_PROT_DATA) && data_seen_reg &&
                      (op_reg == sfp_pkg::OP_IDLE);
  assign start_xfer = cs_rise && (phase_reg == sfp_pkg::PH_ADDR_DONE) &&
                      (op_reg == sfp_pkg::OP_IDLE);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      phase_reg <= sfp_pkg::PH_OPCODE;
      arg_cnt_reg <= '0;
      rd_id_reg <= 1'b0;
      cmp_sel_reg <= 1'b0;
      addr_reg <= '0;
    end else if (CE) begin
      if (!cs_active) begin
        phase_reg <= sfp_pkg::PH_OPCODE;
        arg_cnt_reg <= '0;
      end else if (byte_done) begin
        case (phase_reg)
          sfp_pkg::PH_OPCODE: begin
            arg_cnt_reg <= '0;
            case (rx_byte)
              sfp_pkg::OP_PROT_PROG: phase_reg <= sfp_pkg::PH_PROT_HDR;
              sfp_pkg::OP_PROT_READ: begin
                phase_reg <= sfp_pkg::PH_DUMMY;
                rd_id_reg <= 1'b0;
              end
              sfp_pkg::OP_ID_READ: begin
                phase_reg <= sfp_pkg::PH_DUMMY;
                rd_id_reg <= 1'b1;
              end
              sfp_pkg::OP_PAGE_COPY: begin
                phase_reg <= sfp_pkg::PH_ADDR;
                cmp_sel_reg <= 1'b0;
              end
              sfp_pkg::OP_PAGE_CMP: begin
                phase_reg <= sfp_pkg::PH_ADDR;
                cmp_sel_reg <= 1'b1;
              end
              default: phase_reg <= sfp_pkg::PH_IGNORE;
            endcase
          end
          sfp_pkg::PH_PROT_HDR: begin
            arg_cnt_reg <= arg_cnt_reg + 2'h1;
            if (rx_byte != hdr_byte(arg_cnt_reg)) begin
              phase_reg <= sfp_pkg::PH_IGNORE;
            end else if (arg_cnt_reg == sfp_pkg::LAST_ARG) begin
              phase_reg <= sfp_pkg::PH_PROT_DATA;
            end
          end
          sfp_pkg::PH_DUMMY: begin
            arg_cnt_reg <= arg_cnt_reg + 2'h1;
            if (arg_cnt_reg == sfp_pkg::LAST_ARG) begin
              phase_reg <= rd_id_reg ? sfp_pkg::PH_ID_OUT : sfp_pkg::PH_MAP_OUT;
            end
          end
          sfp_pkg::PH_ADDR: begin
            arg_cnt_reg <= arg_cnt_reg + 2'h1;
            addr_reg <= {addr_reg[15:0], rx_byte};
            if (arg_cnt_reg == sfp_pkg::LAST_ARG) begin
              phase_reg <= sfp_pkg::PH_ADDR_DONE;
            end
          end
          default: phase_reg <= phase_reg;
        endcase
      end
    end
  end

  // Map data pointer wraps through the eight locations.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      data_ptr_reg <= '0;
      data_seen_reg <= 1'b0;
    end else if (CE) begin
      if (!cs_active) begin
        data_ptr_reg <= '0;
        data_seen_reg <= 1'b0;
      end else if (prot_wr) begin
        data_ptr_reg <= data_ptr_reg + 3'h1;
        data_seen_reg <= 1'b1;
      end
    end
  end

  // Page buffer and the FIFO of main-memory bytes.
  logic [7:0] buf_mem [0:sfp_pkg::BUF_BYTES-1];
  logic [8:0] xfer_cnt_reg;
  logic [sfp_pkg::TIMER_W-1:0] timer_reg;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic xfer_busy;
  logic [8:0] page_size;
  logic xfer_last;
  logic byte_diff;
  logic mismatch_acc_reg;
  logic cmp_diff_reg;

  assign xfer_busy = (op_reg == sfp_pkg::OP_COPY) || (op_reg == sfp_pkg::OP_CMP);
  assign fifo_pop = xfer_busy && fifo_valid;
  assign page_size = PAGE_264 ? sfp_pkg::PAGE_SIZE_264 : sfp_pkg::PAGE_SIZE_256;
  assign xfer_last = fifo_pop && (xfer_cnt_reg == page_size - 9'h1);
  assign byte_diff = fifo_pop && (buf_mem[xfer_cnt_reg] != fifo_data);

  sfp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .flush(start_xfer),
    .in_data(MEM_DATA),
    .in_valid(MEM_VALID),
    .in_ready(MEM_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(xfer_busy)
  );

  always_ff @(posedge REF_CLK) begin
    if (CE) begin
      if (prot_wr) begin
        buf_mem[data_ptr_reg] <= rx_byte;
      end else if (fifo_pop && (op_reg == sfp_pkg::OP_COPY)) begin
        buf_mem[xfer_cnt_reg] <= fifo_data;
      end
    end
  end

  // Self-timed operation engine.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      op_reg <= sfp_pkg::OP_IDLE;
      timer_reg <= '0;
      xfer_cnt_reg <= '0;
      mismatch_acc_reg <= 1'b0;
      cmp_diff_reg <= 1'b0;
    end else if (CE) begin
      case (op_reg)
        sfp_pkg::OP_IDLE: begin
          timer_reg <= '0;
          xfer_cnt_reg <= '0;
          mismatch_acc_reg <= 1'b0;
          if (start_prot) begin
            op_reg <= sfp_pkg::OP_PROT;
          end else if (start_xfer) begin
            op_reg <= cmp_sel_reg ? sfp_pkg::OP_CMP : sfp_pkg::OP_COPY;
          end
        end
        sfp_pkg::OP_PROT: begin
          timer_reg <= timer_reg + 1'b1;
          if (timer_reg == PROT_LAST) begin
            op_reg <= sfp_pkg::OP_IDLE;
          end
        end
        sfp_pkg::OP_COPY: begin
          timer_reg <= timer_reg + 1'b1;
          if (fifo_pop) begin
            xfer_cnt_reg <= xfer_cnt_reg + 9'h1;
          end
          if (xfer_last || timer_reg == COPY_LAST) begin
            op_reg <= sfp_pkg::OP_IDLE;
          end
        end
        sfp_pkg::OP_CMP: begin
          timer_reg <= timer_reg + 1'b1;
          if (fifo_pop) begin
            xfer_cnt_reg <= xfer_cnt_reg + 9'h1;
          end
          if (byte_diff) begin
            mismatch_acc_reg <= 1'b1;
          end
          if (xfer_last) begin
            op_reg <= sfp_pkg::OP_IDLE;
            cmp_diff_reg <= mismatch_acc_reg || byte_diff;
          end else if (timer_reg == CMP_LAST) begin
            op_reg <= sfp_pkg::OP_IDLE;
            cmp_diff_reg <= 1'b1;
          end
        end
        default: op_reg <= sfp_pkg::OP_IDLE;
      endcase
    end
  end

  // Memory request toward the main array.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MEM_REQ <= '0;
    end else if (CE) begin
      MEM_REQ.start <= start_xfer;
      if (start_xfer) begin
        MEM_REQ.page <= page_of(addr_reg, PAGE_264);
      end
    end
  end

  // Nonvolatile map, committed from the buffer at the end of the program cycle.
  logic [sfp_pkg::MAP_BYTES-1:0][7:0] map_reg;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      map_reg <= {sfp_pkg::MAP_BYTES{sfp_pkg::PROT_DEFAULT}};
    end else if (CE && op_reg == sfp_pkg::OP_PROT && timer_reg == PROT_LAST) begin
      for (int i = 0; i < sfp_pkg::MAP_BYTES; i++) begin
        map_reg[i] <= buf_mem[i];
      end
    end
  end

  assign PROT_MAP = map_reg;

  // Output shifter, changing data on serial clock falling edges.
  logic [7:0] out_sh_reg;
  logic [2:0] out_bit_reg;
  logic [sfp_pkg::ID_IDX_W-1:0] out_idx_reg;
  logic so_reg;
  logic so_oe_reg;
  logic [7:0] next_byte;
  logic out_phase;

  assign out_phase = (phase_reg == sfp_pkg::PH_MAP_OUT) || (phase_reg == sfp_pkg::PH_ID_OUT);

  always_comb begin
    if (rd_id_reg) begin
      next_byte = ID_BYTE;
    end else if (out_idx_reg < sfp_pkg::ID_IDX_W'(sfp_pkg::MAP_BYTES)) begin
      next_byte = map_reg[out_idx_reg[2:0]];
    end else begin
      next_byte = sfp_pkg::FILL_BYTE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      out_sh_reg <= '0;
      out_bit_reg <= '0;
      out_idx_reg <= '0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else if (CE) begin
      if (!cs_active) begin
        out_idx_reg <= '0;
        out_bit_reg <= '0;
        so_oe_reg <= 1'b0;
      end else if (first_out) begin
        out_sh_reg <= next_byte;
        out_idx_reg <= out_idx_reg + 1'b1;
        out_bit_reg <= '0;
      end else if (sck_fall && out_phase) begin
        so_reg <= out_sh_reg[7];
        so_oe_reg <= 1'b1;
        out_bit_reg <= out_bit_reg + 3'h1;
        if (out_bit_reg == sfp_pkg::LAST_BIT) begin
          out_sh_reg <= next_byte;
          out_idx_reg <= out_idx_reg + 1'b1;
        end else begin
          out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  assign SO = so_reg;
  assign SO_OE = so_oe_reg;
  assign ID_INDEX = out_idx_reg;
  assign STATUS.ready = (op_reg == sfp_pkg::OP_IDLE);
  assign STATUS.cmp_diff = cmp_diff_reg;

endmodule : sfp_cmd

`default_nettype wire

/* sfp_cmd_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_cmd_sva #(
  parameter int PROT_CYCLES = 2000,
  parameter int COPY_CYCLES = 2000,
  parameter int CMP_CYCLES = 2000
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SO,
  input wire logic SO_OE,
  input wire sfp_pkg::sfp_status_t STATUS,
  input wire logic [8*sfp_pkg::MAP_BYTES-1:0] PROT_MAP,
  input wire sfp_pkg::sfp_mem_req_t MEM_REQ
);
  localparam int LONG_OP = PROT_CYCLES > COPY_CYCLES ? PROT_CYCLES : COPY_CYCLES;
  localparam int BUSY_MAX = (LONG_OP > CMP_CYCLES ? LONG_OP : CMP_CYCLES) + 4;
  int busy_cnt;
  // Counts how long the ready flag has been low.
  always_ff @(posedge REF_CLK) begin
    if (RST || STATUS.ready) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  property p_oe_release; CS_N [*5] |-> !SO_OE; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("Serial output driven outside a frame.");
  property p_busy_bound; !STATUS.ready |-> busy_cnt < BUSY_MAX; endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("Busy for longer than the operation time.");
  property p_busy_start; $fell(STATUS.ready) |-> CS_N && $past(CS_N); endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("Busy began while chip select was low.");
  property p_busy_min; $fell(STATUS.ready) |-> !STATUS.ready [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("Busy flag dropped too soon.");
  property p_start_pulse; MEM_REQ.start |=> !MEM_REQ.start && $stable(MEM_REQ.page); endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("Memory start not a single pulse with held page.");
  property p_start_busy; MEM_REQ.start |-> !STATUS.ready && CS_N; endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("Memory start while ready or in a frame.");
  property p_map_hold; $changed(PROT_MAP) |-> $rose(STATUS.ready); endproperty
  a_map_hold: assert property (p_map_hold)
    else $error("Protection map changed outside program end.");
  property p_cmp_hold; $changed(STATUS.cmp_diff) |-> $rose(STATUS.ready); endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("Compare flag changed outside compare end.");
  property p_so_edge; SO_OE && $past(SO_OE) && $changed(SO) |-> !SCK; endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("Serial output changed while the clock was high.");
  c_start: cover property (MEM_REQ.start);
  c_cmp_diff: cover property ($rose(STATUS.ready) && STATUS.cmp_diff);
  c_read_out: cover property ($rose(SO_OE));
  c_map_write: cover property ($changed(PROT_MAP));
endmodule : sfp_cmd_sva
`default_nettype wire

/* sfp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
  input wire logic clk,
  input wire logic so_line,
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  task automatic open_frame();
    cs_n = 1'b0;
    half();
  endtask : open_frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      half();
      sck = 1'b1;
      rx[i] = so_line;
      half();
      sck = 1'b0;
    end
  endtask : xfer
  task automatic close_frame();
    half();
    cs_n = 1'b1;
    si = ~si;
    repeat (6) @(negedge clk);
  endtask : close_frame
endmodule : sfp_host_model
`default_nettype wire

/* tb_serial_flash_protect_security_cmds.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_protect_security_cmds;
  localparam int PROT_C = 20;
  localparam int XFER_C = 600;
  logic ref_clk, rst, page_264, mem_valid, cs_n, sck, si, so, so_oe, so_line, mem_ready;
  logic [7:0] mem_data, id_byte;
  logic [6:0] id_index;
  logic [63:0] prot_map;
  sfp_pkg::sfp_status_t status;
  sfp_pkg::sfp_mem_req_t mem_req;
  logic [7:0] exp_map [8];
  int n_fail, tests_run;
  function automatic logic [7:0] rom(input logic [6:0] i);
    return {1'b0, i} ^ 8'hA5;
  endfunction : rom
  function automatic logic [7:0] pat(input int k);
    return 8'(k) ^ 8'h3C;
  endfunction : pat
  assign id_byte = rom(id_index);
  assign so_line = so_oe ? so : 1'bz;
  sfp_cmd #(.PROT_CYCLES(PROT_C), .COPY_CYCLES(XFER_C), .CMP_CYCLES(XFER_C), .FIFO_DEPTH(4)) u_sfp_cmd (
    .REF_CLK(ref_clk), .RST(rst), .CE(1'b1), .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe),
    .PAGE_264(page_264), .STATUS(status), .PROT_MAP(prot_map), .ID_INDEX(id_index), .ID_BYTE(id_byte),
    .MEM_REQ(mem_req), .MEM_DATA(mem_data), .MEM_VALID(mem_valid), .MEM_READY(mem_ready));
  sfp_host_model u_sfp_host_model (.clk(ref_clk), .so_line(so_line), .cs_n(cs_n), .sck(sck), .si(si));
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic wait_ready();
    for (int i = 0; i < 2000 && status.ready !== 1'b1; i++)
      @(negedge ref_clk);
    check(16'(status.ready), 16'h0001, "ready");
  endtask : wait_ready
  task automatic mem_serve(input logic [9:0] pg, input int n, input int diff_at, input logic m8);
    int k;
    logic ok;
    for (int i = 0; i < 1000 && mem_req.start !== 1'b1; i++)
      @(negedge ref_clk);
    check(16'(mem_req.page), 16'(pg), "page");
    k = 0;
    while (k < n) begin
      if (k % 4 == 3) begin
        mem_valid = 1'b0;
        mem_data = ~mem_data;
        @(negedge ref_clk);
      end
      mem_data = (m8 && k < 8) ? exp_map[k] : pat(k) ^ 8'(k == diff_at);
      mem_valid = 1'b1;
      ok = mem_ready;
      @(negedge ref_clk);
      if (ok)
        k++;
    end
    mem_valid = 1'b0;
  endtask : mem_serve
  task automatic run_cmd(input logic [7:0] op, input logic [9:0] pg, input int n, input int diff_at, input logic m8);
    logic [7:0] rx;
    logic [23:0] addr;
    page_264 = (n == 264);
    addr = page_264 ? {5'h00, pg, 9'h000} : {6'h00, pg, 8'h00};
    fork
      begin
        u_sfp_host_model.open_frame();
        u_sfp_host_model.xfer(op, rx);
        for (int b = 2; b >= 0; b--)
          u_sfp_host_model.xfer(addr[8*b +: 8], rx);
        u_sfp_host_model.close_frame();
      end
      mem_serve(pg, n, diff_at, m8);
    join
    wait_ready();
  endtask : run_cmd
  task automatic read_frame(input logic [7:0] op, input int n, input logic is_map);
    logic [7:0] rx;
    u_sfp_host_model.open_frame();
    u_sfp_host_model.xfer(op, rx);
    repeat (3) u_sfp_host_model.xfer(8'h00, rx);
    for (int k = 0; k < n; k++) begin
      u_sfp_host_model.xfer(8'h00, rx);
      if (k < 8 || !is_map)
        check(16'(rx), 16'(is_map ? exp_map[k] : rom(7'(k))), "read byte");
    end
    u_sfp_host_model.close_frame();
    check(16'(so_oe), 16'h0000, "release");
  endtask : read_frame
  task automatic t_copy_cmp();
    run_cmd(sfp_pkg::OP_PAGE_COPY, 10'h2A5, 264, -1, 1'b0);
    run_cmd(sfp_pkg::OP_PAGE_CMP, 10'h2A5, 264, -1, 1'b0);
    check(16'(status.cmp_diff), 16'h0000, "cmp equal");
    run_cmd(sfp_pkg::OP_PAGE_CMP, 10'h2A5, 264, 263, 1'b0);
    check(16'(status.cmp_diff), 16'h0001, "cmp differ");
  endtask : t_copy_cmp
  task automatic t_map_prog();
    logic [7:0] rx;
    logic [7:0] vals [9];
    vals = '{8'hC0, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h3A};
    u_sfp_host_model.open_frame();
    u_sfp_host_model.xfer(sfp_pkg::OP_PROT_PROG, rx);
    u_sfp_host_model.xfer(sfp_pkg::PROT_SEQ_1, rx);
    u_sfp_host_model.xfer(sfp_pkg::PROT_SEQ_2, rx);
    u_sfp_host_model.xfer(sfp_pkg::PROT_SEQ_3, rx);
    for (int k = 0; k < 9; k++) begin
      u_sfp_host_model.xfer(vals[k], rx);
      exp_map[k % 8] = vals[k];
    end
    u_sfp_host_model.close_frame();
    check(16'(status.ready), 16'h0000, "busy");
    check(16'(prot_map[7:0]), 16'h0000, "map held");
    wait_ready();
    for (int k = 0; k < 8; k++)
      check(16'(prot_map[8*k +: 8]), 16'(exp_map[k]), "map");
  endtask : t_map_prog
  task automatic t_bad_hdr();
    logic [7:0] rx;
    u_sfp_host_model.open_frame();
    u_sfp_host_model.xfer(sfp_pkg::OP_PROT_PROG, rx);
    u_sfp_host_model.xfer(sfp_pkg::PROT_SEQ_1, rx);
    u_sfp_host_model.xfer(sfp_pkg::PROT_SEQ_2, rx);
    repeat (9) u_sfp_host_model.xfer(8'h00, rx);
    u_sfp_host_model.close_frame();
    check(16'(status.ready), 16'h0001, "bad header refused");
  endtask : t_bad_hdr
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #3000000;
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    rst = 1'b1;
    page_264 = 1'b1;
    mem_valid = 1'b0;
    mem_data = 8'h00;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    check(16'(status), 16'h0002, "reset status");
    read_frame(sfp_pkg::OP_ID_READ, 4, 1'b0);
    t_copy_cmp();
    t_map_prog();
    t_bad_hdr();
    read_frame(sfp_pkg::OP_PROT_READ, 9, 1'b1);
    run_cmd(sfp_pkg::OP_PAGE_CMP, 10'h2A5, 256, -1, 1'b1);
    check(16'(status.cmp_diff), 16'h0000, "buffer overwritten");
    summarize();
  end
endmodule : tb_serial_flash_protect_security_cmds
bind sfp_cmd sfp_cmd_sva #(.PROT_CYCLES(PROT_CYCLES), .COPY_CYCLES(COPY_CYCLES), .CMP_CYCLES(CMP_CYCLES)) u_sfp_cmd_sva (
  .REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SO(SO), .SO_OE(SO_OE), .STATUS(STATUS),
  .PROT_MAP(PROT_MAP), .MEM_REQ(MEM_REQ));
`default_nettype wire
